// ---- spm_cfg.svh ----
// Purpose: Register offsets, field positions, reset values and timing counts of the monitor
// Assumes: 8-bit registers addressed by a 9-bit register index
// Notes:   Definitions only
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SPM_ADR_DC_A_LO      9'h10D
`define SPM_ADR_DC_A_HI      9'h10E
`define SPM_ADR_DC_B_LO      9'h10F
`define SPM_ADR_DC_B_HI      9'h110
`define SPM_ADR_SER_CTRL     9'h111
`define SPM_ADR_CTRL         9'h112
`define SPM_ADR_PER_LO       9'h113
`define SPM_ADR_PER_MID      9'h114
`define SPM_ADR_PER_HI       9'h115
`define SPM_ADR_RES_A_LO     9'h116
`define SPM_ADR_RES_A_MID    9'h117
`define SPM_ADR_RES_A_HI     9'h118
`define SPM_ADR_RES_B_LO     9'h119
`define SPM_ADR_RES_B_MID    9'h11A
`define SPM_ADR_RES_B_HI     9'h11B
`define SPM_ADR_DC_CTRL      9'h10C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPM_SER_MAG_BIT      6
`define SPM_SER_PEAK_BIT     5
`define SPM_SER_THR_BIT      4
`define SPM_SER_DIV_HI       3
`define SPM_SER_DIV_LO       2
`define SPM_SER_SLEEP_BIT    1
`define SPM_SER_EN_BIT       0
`define SPM_CTL_CPLX_BIT     7
`define SPM_CTL_MS_BIT       3
`define SPM_CTL_MODE_HI      2
`define SPM_CTL_MODE_LO      1
`define SPM_CTL_EN_BIT       0
`define SPM_DC_FREEZE_BIT    6
`define SPM_DC_BW_HI         5
`define SPM_DC_BW_LO         2
`define SPM_DC_MON_EN_BIT    0

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define SPM_SER_CTRL_RST     8'h04
`define SPM_CTRL_RST         8'h00
`define SPM_DC_CTRL_RST      8'h00
`define SPM_PERIOD_RST       24'h000080
`define SPM_PERIOD_MIN       24'h000080
`define SPM_DC_BW_MAX        4'hD
`define SPM_MAG_BITS         20
`define SPM_PEAK_BITS        13

`endif

// ---- spm_pkg.sv ----
// Purpose: Types shared by the signal monitor files
// Assumes: spm_cfg.svh holds the numbers
// Notes:   Types only
package spm_pkg;

  typedef enum logic [1:0] {
    SPM_MODE_POWER,
    SPM_MODE_PEAK,
    SPM_MODE_THR,
    SPM_MODE_THR2
  } spm_mode_t;

  typedef struct packed {
    logic       mag_out;
    logic       peak_out;
    logic       thr_out;
    logic [1:0] div_sel;
    logic       sleep;
    logic       ser_en;
  } spm_ser_cfg_t;

  typedef struct packed {
    logic [7:0] addr_lo;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } spm_reg_req_t;

endpackage

// ---- spm_serial.sv ----
// Purpose: Serial output of monitor results with divided clock
// Assumes: Results arrive as a one-cycle load pulse with both channels
// Notes:   Frame order is power, peak, threshold; channel A before B, MSB first
`timescale 1ns/100ps
`include "spm_cfg.svh"
module spm_serial
  import spm_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Configuration
  input  wire spm_ser_cfg_t cfg,
  // Results
  input  wire logic         load,
  input  wire logic [19:0]  pwr_a,
  input  wire logic [19:0]  pwr_b,
  input  wire logic [12:0]  peak_a,
  input  wire logic [12:0]  peak_b,
  input  wire logic [12:0]  thr_a,
  input  wire logic [12:0]  thr_b,
  // Serial port
  output logic              ser_clk,
  output logic              ser_data,
  output logic              ser_frame
);

  localparam int SHW = 92;

  logic [SHW-1:0] shift_r;
  logic [6:0]     bits_r;
  logic [2:0]     div_cnt_r;
  logic [2:0]     half;
  logic           tick;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_comb begin
    case (cfg.div_sel)
      2'h2:    half = 3'h1;
      2'h3:    half = 3'h3;
      default: half = 3'h0;
    endcase
  end

  assign tick = (div_cnt_r == half);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_r <= 3'h0;
    end else if (tick) begin
      div_cnt_r <= 3'h0;
    end else begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Shifter: data changes on falling serial clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r  <= '0;
      bits_r   <= 7'h0;
      ser_clk  <= 1'b0;
      ser_data <= 1'b0;
      ser_frame <= 1'b0;
    end else begin
      if (load && cfg.ser_en && bits_r == 7'h0 && !ser_frame) begin
        shift_r <= '0;
        bits_r  <= 7'h0;
        if (cfg.mag_out) begin
          shift_r <= {pwr_a, pwr_b, 52'h0};
          bits_r  <= 7'd40;
        end
        if (cfg.peak_out) begin
          shift_r <= cfg.mag_out ? {pwr_a, pwr_b, peak_a, peak_b, 26'h0}
                                 : {peak_a, peak_b, 66'h0};
          bits_r  <= cfg.mag_out ? 7'd66 : 7'd26;
        end
        if (cfg.thr_out) begin
          case ({cfg.mag_out, cfg.peak_out})
            2'b11:   shift_r <= {pwr_a, pwr_b, peak_a, peak_b, thr_a, thr_b};
            2'b10:   shift_r <= {pwr_a, pwr_b, thr_a, thr_b, 26'h0};
            2'b01:   shift_r <= {peak_a, peak_b, thr_a, thr_b, 40'h0};
            default: shift_r <= {thr_a, thr_b, 66'h0};
          endcase
          case ({cfg.mag_out, cfg.peak_out})
            2'b11:   bits_r <= 7'd92;
            2'b10:   bits_r <= 7'd66;
            2'b01:   bits_r <= 7'd52;
            default: bits_r <= 7'd26;
          endcase
        end
      end else if (tick) begin
        if (bits_r != 7'h0) begin
          ser_clk <= ~ser_clk;
          if (ser_clk) begin
            ser_data  <= shift_r[SHW-1];
            ser_frame <= 1'b1;
            shift_r   <= {shift_r[SHW-2:0], 1'b0};
            bits_r    <= bits_r - 7'h1;
          end else if (!ser_frame) begin
            ser_data  <= shift_r[SHW-1];
            ser_frame <= 1'b1;
            shift_r   <= {shift_r[SHW-2:0], 1'b0};
            bits_r    <= bits_r - 7'h1;
            ser_clk   <= 1'b0;
          end
        end else if (ser_frame) begin
          // Last bit still gets its rising edge; frame drops as the clock falls
          ser_clk   <= ~ser_clk;
          ser_frame <= ~ser_clk;
        end else begin
          ser_clk <= cfg.sleep ? 1'b0 : ~ser_clk;
        end
      end
    end
  end

endmodule // spm_serial

// ---- spm_monitor.sv ----
// Purpose: Dual-channel signal monitor with register file and serial result output
// Assumes: One sample per channel each clock; 14-bit two's complement samples
// Notes:   Registers reached through a simple 8-bit register port
`timescale 1ns/100ps
`include "spm_cfg.svh"
module spm_monitor
  import spm_pkg::*;
#(
  parameter int DW = 14
)(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Samples
  input  wire logic [DW-1:0] samp_a,
  input  wire logic [DW-1:0] samp_b,
  input  wire logic [12:0]   thr_level,
  // Register port
  input  wire logic [8:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic [7:0]    reg_wdata,
  output logic [7:0]         reg_rdata,
  // Serial result port
  output logic               monitor_serial_clock,
  output logic               monitor_serial_data,
  output logic               monitor_serial_frame,
  // Status
  output logic               result_valid
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [12:0] mag13(input logic signed [DW-1:0] s);
    logic [DW-1:0] m;
    m = s[DW-1] ? DW'(-s) : DW'(s);
    return m[DW-1] ? 13'h1FFF : m[12:0];
  endfunction

  function automatic logic [19:0] isqrt40(input logic [39:0] v);
    logic [39:0] rem;
    logic [39:0] root;
    logic [39:0] bit_v;
    rem   = v;
    root  = 40'h0;
    bit_v = 40'h1 << 38;
    for (int i = 0; i < 20; i++) begin
      if (rem >= root + bit_v) begin
        rem  = rem - (root + bit_v);
        root = (root >> 1) + bit_v;
      end else begin
        root = root >> 1;
      end
      bit_v = bit_v >> 2;
    end
    return root[19:0];
  endfunction

  function automatic logic [19:0] pwr_result(input logic [55:0] acc, input logic [23:0] n,
                                             input logic ms);
    logic [39:0] mean;
    mean = 40'(acc / {32'h0, n});
    return ms ? mean[39:20] : isqrt40(mean);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  spm_ser_cfg_t      ser_cfg;
  logic [7:0]        ser_ctrl_r;
  logic [7:0]        ctrl_r;
  logic [7:0]        dc_ctrl_r;
  logic [23:0]       period_r;
  logic [19:0]       res_a_r;
  logic [19:0]       res_b_r;
  logic signed [DW+19:0] dc_acc_a_r;
  logic signed [DW+19:0] dc_acc_b_r;
  logic signed [DW-1:0]  dc_a;
  logic signed [DW-1:0]  dc_b;
  logic [55:0]       acc_a_r;
  logic [55:0]       acc_b_r;
  logic [12:0]       peak_a_r;
  logic [12:0]       peak_b_r;
  logic [19:0]       cnt_a_r;
  logic [19:0]       cnt_b_r;
  logic [55:0]       acc_a_nxt;
  logic [55:0]       acc_b_nxt;
  logic [12:0]       peak_a_nxt;
  logic [12:0]       peak_b_nxt;
  logic [19:0]       cnt_a_nxt;
  logic [19:0]       cnt_b_nxt;
  logic [12:0]       mag_a;
  logic [12:0]       mag_b;
  logic [23:0]       cyc_r;
  logic [23:0]       period_eff;
  logic              mon_en;
  logic              last;
  logic [19:0]       pwr_a;
  logic [19:0]       pwr_b;
  logic signed [DW:0] xa;
  logic signed [DW:0] xb;
  logic [4:0]        bw;
  spm_mode_t         mode;

  assign mon_en = ctrl_r[`SPM_CTL_EN_BIT];
  assign mode   = spm_mode_t'(ctrl_r[`SPM_CTL_MODE_HI:`SPM_CTL_MODE_LO]);
  assign ser_cfg = spm_ser_cfg_t'(ser_ctrl_r[6:0]);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ser_ctrl_r <= `SPM_SER_CTRL_RST;
      ctrl_r     <= `SPM_CTRL_RST;
      dc_ctrl_r  <= `SPM_DC_CTRL_RST;
      period_r   <= `SPM_PERIOD_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `SPM_ADR_SER_CTRL: ser_ctrl_r     <= {1'b0, reg_wdata[6:0]};
        `SPM_ADR_CTRL:     ctrl_r         <= {reg_wdata[7], 3'h0, reg_wdata[3:0]};
        `SPM_ADR_DC_CTRL:  dc_ctrl_r      <= {1'b0, reg_wdata[6:0]};
        `SPM_ADR_PER_LO:   period_r[7:0]  <= reg_wdata;
        `SPM_ADR_PER_MID:  period_r[15:8] <= reg_wdata;
        `SPM_ADR_PER_HI:   period_r[23:16] <= reg_wdata;
        default:           ;
      endcase
    end
  end

  always_comb begin
    case (reg_addr)
      `SPM_ADR_DC_A_LO:   reg_rdata = dc_a[7:0];
      `SPM_ADR_DC_A_HI:   reg_rdata = {2'h0, dc_a[13:8]};
      `SPM_ADR_DC_B_LO:   reg_rdata = dc_b[7:0];
      `SPM_ADR_DC_B_HI:   reg_rdata = {2'h0, dc_b[13:8]};
      `SPM_ADR_DC_CTRL:   reg_rdata = dc_ctrl_r;
      `SPM_ADR_SER_CTRL:  reg_rdata = ser_ctrl_r;
      `SPM_ADR_CTRL:      reg_rdata = ctrl_r;
      `SPM_ADR_PER_LO:    reg_rdata = period_r[7:0];
      `SPM_ADR_PER_MID:   reg_rdata = period_r[15:8];
      `SPM_ADR_PER_HI:    reg_rdata = period_r[23:16];
      `SPM_ADR_RES_A_LO:  reg_rdata = res_a_r[7:0];
      `SPM_ADR_RES_A_MID: reg_rdata = res_a_r[15:8];
      `SPM_ADR_RES_A_HI:  reg_rdata = {4'h0, res_a_r[19:16]};
      `SPM_ADR_RES_B_LO:  reg_rdata = res_b_r[7:0];
      `SPM_ADR_RES_B_MID: reg_rdata = res_b_r[15:8];
      `SPM_ADR_RES_B_HI:  reg_rdata = {4'h0, res_b_r[19:16]};
      default:            reg_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // DC estimate: leaky average, bandwidth from k
  // ----------------------------------------------------------------
  assign bw = (dc_ctrl_r[`SPM_DC_BW_HI:`SPM_DC_BW_LO] > `SPM_DC_BW_MAX)
              ? 5'(`SPM_DC_BW_MAX) + 5'd6 : 5'(dc_ctrl_r[`SPM_DC_BW_HI:`SPM_DC_BW_LO]) + 5'd6;
  assign dc_a = DW'(dc_acc_a_r >>> bw);
  assign dc_b = DW'(dc_acc_b_r >>> bw);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dc_acc_a_r <= '0;
      dc_acc_b_r <= '0;
    end else if (mon_en && !dc_ctrl_r[`SPM_DC_FREEZE_BIT]) begin
      dc_acc_a_r <= dc_acc_a_r + (DW+20)'($signed(samp_a)) - (DW+20)'(dc_a);
      dc_acc_b_r <= dc_acc_b_r + (DW+20)'($signed(samp_b)) - (DW+20)'(dc_b);
    end
  end

  // ----------------------------------------------------------------
  // Measurement
  // ----------------------------------------------------------------
  assign period_eff = (period_r < `SPM_PERIOD_MIN) ? `SPM_PERIOD_MIN : period_r;
  assign last = (cyc_r >= period_eff - 24'h1);

  always_comb begin
    if (dc_ctrl_r[`SPM_DC_MON_EN_BIT]) begin
      xa = (DW+1)'($signed(samp_a)) - (DW+1)'(dc_a);
      xb = (DW+1)'($signed(samp_b)) - (DW+1)'(dc_b);
    end else begin
      xa = (DW+1)'($signed(samp_a));
      xb = (DW+1)'($signed(samp_b));
    end
  end

  // ----------------------------------------------------------------
  // Running figures
  // ----------------------------------------------------------------
  // Include the current sample, so a period of N cycles covers N samples
  always_comb begin
    mag_a = mag13(samp_a);
    mag_b = mag13(samp_b);
    if (ctrl_r[`SPM_CTL_CPLX_BIT]) begin
      acc_a_nxt = acc_a_r + 56'(xa * xa) + 56'(xb * xb);
      acc_b_nxt = acc_b_r + 56'(xa * xa) + 56'(xb * xb);
    end else begin
      acc_a_nxt = acc_a_r + 56'(xa * xa);
      acc_b_nxt = acc_b_r + 56'(xb * xb);
    end
    peak_a_nxt = (mag_a > peak_a_r) ? mag_a : peak_a_r;
    peak_b_nxt = (mag_b > peak_b_r) ? mag_b : peak_b_r;
    // Crossing counts saturate rather than wrap
    cnt_a_nxt  = cnt_a_r;
    cnt_b_nxt  = cnt_b_r;
    if (mag_a > thr_level && cnt_a_r != 20'hFFFFF) begin
      cnt_a_nxt = cnt_a_r + 20'h1;
    end
    if (mag_b > thr_level && cnt_b_r != 20'hFFFFF) begin
      cnt_b_nxt = cnt_b_r + 20'h1;
    end
  end

  assign pwr_a = pwr_result(acc_a_nxt, period_eff, ctrl_r[`SPM_CTL_MS_BIT]);
  assign pwr_b = pwr_result(acc_b_nxt, period_eff, ctrl_r[`SPM_CTL_MS_BIT]);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_r    <= 24'h0;
      acc_a_r  <= 56'h0;
      acc_b_r  <= 56'h0;
      peak_a_r <= 13'h0;
      peak_b_r <= 13'h0;
      cnt_a_r  <= 20'h0;
      cnt_b_r  <= 20'h0;
    end else if (!mon_en || last) begin
      cyc_r    <= 24'h0;
      acc_a_r  <= 56'h0;
      acc_b_r  <= 56'h0;
      peak_a_r <= 13'h0;
      peak_b_r <= 13'h0;
      cnt_a_r  <= 20'h0;
      cnt_b_r  <= 20'h0;
    end else begin
      cyc_r    <= cyc_r + 24'h1;
      acc_a_r  <= acc_a_nxt;
      acc_b_r  <= acc_b_nxt;
      peak_a_r <= peak_a_nxt;
      peak_b_r <= peak_b_nxt;
      cnt_a_r  <= cnt_a_nxt;
      cnt_b_r  <= cnt_b_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      res_a_r      <= 20'h0;
      res_b_r      <= 20'h0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= mon_en && last;
      if (mon_en && last) begin
        case (mode)
          SPM_MODE_POWER: begin
            res_a_r <= pwr_a;
            res_b_r <= pwr_b;
          end
          SPM_MODE_PEAK: begin
            res_a_r <= {7'h0, peak_a_nxt};
            res_b_r <= {7'h0, peak_b_nxt};
          end
          default: begin
            res_a_r <= cnt_a_nxt;
            res_b_r <= cnt_b_nxt;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  spm_serial u_serial (
    .clk      (clk),
    .reset_n  (reset_n),
    .cfg      (ser_cfg),
    .load     (mon_en && last),
    .pwr_a    (pwr_a),
    .pwr_b    (pwr_b),
    .peak_a   (peak_a_nxt),
    .peak_b   (peak_b_nxt),
    .thr_a    (cnt_a_nxt[12:0]),
    .thr_b    (cnt_b_nxt[12:0]),
    .ser_clk  (monitor_serial_clock),
    .ser_data (monitor_serial_data),
    .ser_frame(monitor_serial_frame)
  );

endmodule // spm_monitor

// ---- spm_monitor_asserts.sv ----
// Purpose: Port checks for the signal monitor
// Assumes: Register shadows follow writes seen at the register port
// Notes:   Bound to spm_monitor after the module
`timescale 1ns/100ps
module spm_monitor_asserts (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Register port
  input wire logic [8:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Serial and status
  input wire logic       monitor_serial_clock,
  input wire logic       monitor_serial_frame,
  input wire logic       result_valid
);
  logic [7:0] ser_r;
  logic [7:0] ctl_r;
  logic       sclk_r;
  logic       in_fr_r;
  logic [3:0] gap_r;
  logic [3:0] half;
  logic       tog;

  assign tog  = monitor_serial_clock != sclk_r;
  assign half = (ser_r[3:2] == 2'h3) ? 4'h4 : (ser_r[3:2] == 2'h2) ? 4'h2 : 4'h1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ser_r <= 8'h04;
      ctl_r <= 8'h00;
    end else if (reg_wr && reg_addr == 9'h111) begin
      ser_r <= reg_wdata;
    end else if (reg_wr && reg_addr == 9'h112) begin
      ctl_r <= reg_wdata;
    end
  end

  // Cycles since the serial clock last changed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_r  <= 1'b0;
      in_fr_r <= 1'b0;
      gap_r   <= 4'h0;
    end else begin
      sclk_r  <= monitor_serial_clock;
      in_fr_r <= monitor_serial_frame && (in_fr_r || tog);
      gap_r   <= tog ? 4'h1 : (gap_r == 4'hF) ? gap_r : gap_r + 4'h1;
    end
  end

  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_idle;
    (ser_r[1] && !monitor_serial_frame) [*8];
  endsequence
  sequence s_ctl_wr;
    reg_wr && reg_addr == 9'h112 ##1 reg_addr == 9'h112;
  endsequence

  property p_div; monitor_serial_frame && in_fr_r && tog |-> gap_r == half; endproperty
  a_div: assert property (p_div) else $error("serial clock rate wrong");
  property p_sleep; s_idle |-> !monitor_serial_clock; endproperty
  a_sleep: assert property (p_sleep) else $error("idle serial clock not low");
  property p_start; $rose(monitor_serial_frame) |-> ser_r[0] || $past(ser_r[0], 8); endproperty
  a_start: assert property (p_start) else $error("frame while port off");
  property p_off; (!ctl_r[0]) [*2] |-> !result_valid; endproperty
  a_off: assert property (p_off) else $error("result while disabled");
  property p_gap; result_valid |=> !result_valid [*8]; endproperty
  a_gap: assert property (p_gap) else $error("results too close");
  property p_ctl;
    s_ctl_wr |-> reg_rdata == {$past(reg_wdata[7]), 3'h0, $past(reg_wdata[3:0])};
  endproperty
  a_ctl: assert property (p_ctl) else $error("control readback wrong");
  property p_hi_a; reg_addr == 9'h118 |-> reg_rdata[7:4] == 4'h0; endproperty
  a_hi_a: assert property (p_hi_a) else $error("result A top bits set");
  property p_hi_b; reg_addr == 9'h11B |-> reg_rdata[7:4] == 4'h0; endproperty
  a_hi_b: assert property (p_hi_b) else $error("result B top bits set");
  property p_dc_hi; reg_addr == 9'h110 |-> reg_rdata[7:6] == 2'h0; endproperty
  a_dc_hi: assert property (p_dc_hi) else $error("offset B top bits set");
  property p_hold;
    reg_addr == 9'h116 && $stable(reg_addr) && $changed(reg_rdata) |-> ##[0:1] result_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("result changed off period end");
endmodule // spm_monitor_asserts

bind spm_monitor spm_monitor_asserts u_chk (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .result_valid(result_valid),
  .monitor_serial_clock(monitor_serial_clock), .monitor_serial_frame(monitor_serial_frame)
);

// ---- spm_rx_model.sv ----
// Purpose: Receiver of the monitor serial result stream
// Assumes: Data is taken on the rising serial clock while frame is high
// Notes:   Holds the bits of the latest frame, last bit lowest
`timescale 1ns/100ps
module spm_rx_model (
  // Serial port
  input wire logic     sclk,
  input wire logic     frame,
  input wire logic     sdata,
  // Captured frame
  output logic [127:0] bits,
  output int           nbits
);
  logic in_fr = 1'b0;

  // A new frame starts at its first rising clock; the fall of frame re-arms it
  always @(posedge sclk or negedge frame) begin
    if (!frame) begin
      in_fr <= 1'b0;
    end else if (!in_fr) begin
      bits  <= {127'h0, sdata};
      nbits <= 1;
      in_fr <= 1'b1;
    end else begin
      bits  <= {bits[126:0], sdata};
      nbits <= nbits + 1;
    end
  end
endmodule // spm_rx_model

// ---- tb_signal_power_monitor.sv ----
// Purpose: Self-checking bench for the signal monitor
// Assumes: Constant samples give exact power, peak and crossing figures
// Notes:   Serial frames are captured by spm_rx_model
`timescale 1ns/100ps
module tb_signal_power_monitor;
  logic         clk;
  logic         reset_n;
  logic [13:0]  samp_a;
  logic [13:0]  samp_b;
  logic [12:0]  thr_level;
  logic [8:0]   reg_addr;
  logic         reg_wr;
  logic [7:0]   reg_wdata;
  logic [7:0]   reg_rdata;
  logic         ser_clk;
  logic         ser_data;
  logic         ser_frame;
  logic         result_valid;
  logic [127:0] rx_bits;
  int           rx_nbits;
  int           n_mismatch = 0;
  int           comparisons = 0;
  logic [7:0]   scfg [4] = '{8'h77, 8'h4B, 8'h2F, 8'h17};

  always #10 clk = ~clk;

  spm_monitor DUT (
    .clk(clk), .reset_n(reset_n), .samp_a(samp_a), .samp_b(samp_b), .thr_level(thr_level),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .monitor_serial_clock(ser_clk), .monitor_serial_data(ser_data),
    .monitor_serial_frame(ser_frame), .result_valid(result_valid)
  );
  spm_rx_model u_rx (
    .sclk(ser_clk), .frame(ser_frame), .sdata(ser_data), .bits(rx_bits), .nbits(rx_nbits)
  );

  task automatic print_verdict();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic fail_wait();
    n_mismatch++;
    $display("mismatch at %0t: wait ran out", $time);
    print_verdict();
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic rc(input logic [8:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic rres(input logic [8:0] a, output logic [19:0] v);
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    rd(a, b0);
    rd(a + 9'h001, b1);
    rd(a + 9'h002, b2);
    v = {b2[3:0], b1, b0};
  endtask
  task automatic wait_rv(output int n);
    n = 0;
    while (result_valid !== 1'b1) begin
      if (n == 2000) begin
        fail_wait();
      end
      @(negedge clk);
      n++;
    end
    @(negedge clk);
  endtask
  task automatic wait_fr(input logic lvl);
    int n = 0;
    while (ser_frame !== lvl) begin
      if (n == 3000) begin
        fail_wait();
      end
      @(negedge clk);
      n++;
    end
  endtask
  // Two periods so the first, started at enable, is settled
  task automatic meas(input logic [7:0] c, input logic [13:0] a, input logic [13:0] b,
                      input logic [19:0] ea, input logic [19:0] eb);
    logic [19:0] v;
    int          n;
    wr(9'h112, 8'h00);
    samp_a = a;
    samp_b = b;
    wr(9'h112, c);
    reg_addr = 9'h116;
    wait_rv(n);
    wait_rv(n);
    rres(9'h116, v);
    chk(v, ea);
    rres(9'h119, v);
    chk(v, eb);
  endtask
  // Frame for samples 100 and -50 with crossing level 60
  function automatic void exp_frame(input logic [7:0] c, output int nb, output logic [127:0] v);
    nb = 0;
    v  = 128'h0;
    if (c[6]) begin
      v  = {v[87:0], 20'h00064, 20'h00032};
      nb += 40;
    end
    if (c[5]) begin
      v  = {v[101:0], 13'h0064, 13'h0032};
      nb += 26;
    end
    if (c[4]) begin
      v  = {v[101:0], 13'h0080, 13'h0000};
      nb += 26;
    end
  endfunction

  initial begin
    logic [19:0]  v;
    logic [127:0] ev;
    int           n;
    int           nb;
    int           hits;
    clk       = 1'b0;
    reset_n   = 1'b0;
    samp_a    = 14'h0064;
    samp_b    = 14'h3FCE;
    thr_level = 13'h003C;
    reg_addr  = 9'h000;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    rc(9'h111, 8'h04);
    rc(9'h112, 8'h00);
    rc(9'h113, 8'h80);
    rc(9'h114, 8'h00);
    rc(9'h115, 8'h00);
    wr(9'h112, 8'hFF);
    rc(9'h112, 8'h8F);
    wr(9'h111, 8'hFF);
    rc(9'h111, 8'h7F);
    wr(9'h111, 8'h00);
    wr(9'h112, 8'h00);
    wr(9'h116, 8'hFF);
    rc(9'h116, 8'h00);
    wr(9'h11C, 8'hAA);
    rc(9'h11C, 8'h00);
    meas(8'h01, 14'h0064, 14'h3FCE, 20'h00064, 20'h00032);
    meas(8'h03, 14'h0064, 14'h3FCE, 20'h00064, 20'h00032);
    meas(8'h05, 14'h0064, 14'h3FCE, 20'h00080, 20'h00000);
    meas(8'h07, 14'h0064, 14'h3FCE, 20'h00080, 20'h00000);
    meas(8'h81, 14'h001E, 14'h0028, 20'h00032, 20'h00032);
    meas(8'h09, 14'h1000, 14'h3000, 20'h00010, 20'h00010);
    wr(9'h112, 8'h00);
    hits = 0;
    repeat (300) begin
      @(negedge clk);
      hits += (result_valid === 1'b1) ? 1 : 0;
    end
    chk(hits, 0);
    samp_a = 14'h0064;
    samp_b = 14'h3FCE;
    wr(9'h112, 8'h01);
    wr(9'h113, 8'h10);
    wait_rv(n);
    wait_rv(n);
    chk(n + 1, 128);
    wr(9'h114, 8'h01);
    wr(9'h113, 8'h00);
    wait_rv(n);
    wait_rv(n);
    chk(n + 1, 256);
    wr(9'h114, 8'h00);
    wr(9'h113, 8'h80);
    foreach (scfg[i]) begin
      wr(9'h111, scfg[i]);
      wait_fr(1'b1);
      wait_fr(1'b0);
      wr(9'h111, 8'h00);
      repeat (20) @(negedge clk);
      wait_fr(1'b0);
      exp_frame(scfg[i], nb, ev);
      chk(rx_nbits, nb);
      chk(rx_bits, ev);
      wait_rv(n);
      repeat (20) @(negedge clk);
      chk(ser_frame, 1'b0);
    end
    wr(9'h10C, 8'h01);
    repeat (20) begin
      wait_rv(n);
    end
    rc(9'h110, 8'h3F);
    rc(9'h10F, 8'hCE);
    rres(9'h116, v);
    chk(v, 20'h00000);
    print_verdict();
  end
endmodule // tb_signal_power_monitor
